/* File: verilog/clg_pkg.sv */
// clg_pkg: constants and types shared by the counter core files
// assumes nothing beyond a systemverilog compiler
package clg_pkg;
   localparam int CLG_W = 32;
   localparam logic [31:0] CLG_MAX = 32'h7FFFFFFF;
   localparam logic [31:0] CLG_MIN = 32'h80000000;
   localparam logic [31:0] CLG_ZERO = 32'h00000000;
   localparam logic [31:0] CLG_RST_DEFAULT = 32'h00000000;
   localparam int CLG_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      CLG_MODE_CONT = 2'h0,
      CLG_MODE_ONCE = 2'h1,
      CLG_MODE_PER = 2'h3
   } clg_mode_t;

   typedef enum logic [1:0] {
      CLG_DIR_NONE = 2'h0,
      CLG_DIR_UP = 2'h1,
      CLG_DIR_DOWN = 2'h3
   } clg_dir_t;

   // gate state machine, gray along closed, open, stopped
   typedef enum logic [1:0] {
      CLG_G_CLOSED = 2'h0,
      CLG_G_OPEN = 2'h1,
      CLG_G_HALT = 2'h3
   } clg_gate_t;
endpackage : clg_pkg

/* File: verilog/clg_pin_if.sv */
// clg_pin_if: synchronised pin edge pulses and gate level passed from the pin stage to the core
// assumes one clock domain
`timescale 1ns/1ps
interface clg_pin_if;
   logic up;
   logic dn;
   logic hw_gate;
   logic sync_ev;
   logic latch_ev;
   logic sample;
   modport src (output up, dn, hw_gate, sync_ev, latch_ev, sample);
   modport dst (input up, dn, hw_gate, sync_ev, latch_ev, sample);
endinterface : clg_pin_if

/* File: verilog/clg_pin_sync.sv */
// clg_pin_sync: two-stage synchronisers plus edge pulses for pin inputs
// assumes pins are asynchronous to i_clk_sys
`timescale 1ns/1ps
module clg_pin_sync (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // raw pins
   input wire logic i_up,
   input wire logic i_dn,
   input wire logic i_hw_gate,
   input wire logic i_sync,
   input wire logic i_latch,
   input wire logic i_sample,
   // synchronised outputs
   clg_pin_if.src o_pins
);
   localparam int N = 6;
   wire [N-1:0] raw = {i_sample, i_latch, i_sync, i_hw_gate, i_dn, i_up};
   logic [N-1:0] s1;
   logic [N-1:0] s2;
   logic [N-1:0] s3;
   wire [N-1:0] rise = s2 & ~s3;

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_sync
         always_ff @(posedge i_clk_sys or negedge i_nrst) begin
            if (!i_nrst) begin
               s1[g] <= 1'b0;
               s2[g] <= 1'b0;
               s3[g] <= 1'b0;
            end else begin
               s1[g] <= raw[g];
               s2[g] <= s1[g];
               s3[g] <= s2[g];
            end
         end
      end
   endgenerate

   // count pulses and events act on the rising edge; gate is a level
   assign o_pins.up = rise[0];
   assign o_pins.dn = rise[1];
   assign o_pins.hw_gate = s2[2];
   assign o_pins.sync_ev = rise[3];
   assign o_pins.latch_ev = rise[4];
   assign o_pins.sample = rise[5];
endmodule : clg_pin_sync

/* File: verilog/clg_gate.sv */
// clg_gate: gate state machine for software and hardware gates
// assumes control inputs already synchronous to i_clk_sys
`timescale 1ns/1ps
module clg_gate (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // control
   input wire logic i_sw_bit,
   input wire logic i_hw_en,
   input wire logic i_hw_level,
   input wire logic i_limit_stop,
   // status
   output logic o_open,
   output logic o_start
);
   clg_pkg::clg_gate_t state;
   clg_pkg::clg_gate_t next_state;
   logic sw_prev;
   logic hw_prev;
   wire sw_rise = i_sw_bit & ~sw_prev;
   wire hw_rise = i_hw_level & ~hw_prev;
   wire hw_ok = ~i_hw_en | i_hw_level;
   wire start_req = (sw_rise & hw_ok) | (i_hw_en & hw_rise & i_sw_bit);

   always_comb begin
      next_state = state;
      case (state)
         clg_pkg::CLG_G_CLOSED: begin
            if (start_req) next_state = clg_pkg::CLG_G_OPEN;
         end
         clg_pkg::CLG_G_OPEN: begin
            if (!i_sw_bit || !hw_ok) next_state = clg_pkg::CLG_G_CLOSED;
            else if (i_limit_stop) next_state = clg_pkg::CLG_G_HALT;
         end
         clg_pkg::CLG_G_HALT: begin
            // once mode: reopen needs a fresh edge
            if (!i_sw_bit) next_state = clg_pkg::CLG_G_CLOSED;
            else if (start_req) next_state = clg_pkg::CLG_G_OPEN;
         end
         default: next_state = clg_pkg::CLG_G_CLOSED;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= clg_pkg::CLG_G_CLOSED;
         sw_prev <= 1'b0;
         hw_prev <= 1'b0;
      end else begin
         state <= next_state;
         sw_prev <= i_sw_bit;
         hw_prev <= i_hw_level;
      end
   end

   assign o_open = (state == clg_pkg::CLG_G_OPEN);
   // start loads the staged value; continuing is not a start
   assign o_start = start_req && (state != clg_pkg::CLG_G_OPEN)
      && (next_state == clg_pkg::CLG_G_OPEN);
endmodule : clg_gate

/* File: verilog/clg_core.sv */
// clg_core: 32-bit signed counter core with continuous, once and periodic
// counting, direct and staged loading, and sampled feedback.
// assumes control bits come from a bus interface on i_clk_sys and pins are
// asynchronous; parameter assignment is the i_param_strobe pulse.
//
// Notes on behaviour
// - count is signed, from -2147483648 up to +2147483647.
// - mode is continuous, once or periodic, fixed by parameter assignment.
// - direct-load command replaces the count at once with the load value.
// - once/periodic, no main direction: staged value loads at either limit.
// - once/periodic, direction up: staged value loads at set high limit.
// - once/periodic, direction down: staged value loads on reaching zero.
// - gate start loads staged value, also when reopening a halted count.
// - synchronisation and latch-retrigger events also load staged value.
// - main direction picks reset states and load limits, not pulse direction.
// - after assignment values reset to 0, or high limit when down.
// - control accepted every cycle, response returned at the next sampling instant.
// - feedback shows count or latch and status at sampling instant.
// - pin-caused change shows only if before the sampling instant.
// - continuous mode wraps at limits without losing the pulse.
// - once mode closes gate on overflow or underflow; reopen needed.
// - software gate opens on rising bit edge, closes when bit clears.
`timescale 1ns/1ps
module clg_core #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // parameter assignment
   input wire logic i_param_strobe,
   input wire logic [1:0] i_mode,
   input wire logic [1:0] i_main_dir,
   input wire logic [W-1:0] i_high_limit,
   input wire logic i_hw_gate_en,
   input wire logic i_sync_en,
   input wire logic i_latch_en,
   // control interface
   input wire logic i_software_gate_bit,
   input wire logic i_direct_count_load,
   input wire logic [W-1:0] i_load_data,
   input wire logic i_staged_load_wr,
   input wire logic i_cmp1_wr,
   input wire logic i_cmp2_wr,
   input wire logic i_show_latch,
   // pins
   input wire logic i_pulse_up,
   input wire logic i_pulse_dn,
   input wire logic i_hw_gate,
   input wire logic i_sync,
   input wire logic i_latch,
   input wire logic i_input_sampling_instant,
   // feedback
   output logic [W-1:0] o_feedback,
   output logic o_gate_open,
   output logic o_overflow,
   output logic o_underflow,
   output logic o_fb_valid,
   output logic [W-1:0] o_cmp1,
   output logic [W-1:0] o_cmp2
);
   clg_pin_if pins();

   clg_pin_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_up(i_pulse_up),
      .i_dn(i_pulse_dn),
      .i_hw_gate(i_hw_gate),
      .i_sync(i_sync),
      .i_latch(i_latch),
      .i_sample(i_input_sampling_instant),
      .o_pins(pins)
   );

   // assigned parameters, held from the last assignment
   clg_pkg::clg_mode_t mode;
   clg_pkg::clg_dir_t dir;
   logic [W-1:0] high_lim;
   logic hw_en;
   logic sync_en;
   logic latch_en;

   logic signed [W-1:0] count;
   logic signed [W-1:0] staged_load_value;
   logic signed [W-1:0] latch_val;
   logic [W-1:0] cmp1;
   logic [W-1:0] cmp2;
   logic ovf;
   logic unf;

   // count limits for the current mode and direction
   wire is_cont = (mode == clg_pkg::CLG_MODE_CONT);
   wire is_once = (mode == clg_pkg::CLG_MODE_ONCE);
   wire dir_up = (dir == clg_pkg::CLG_DIR_UP);
   wire dir_dn = (dir == clg_pkg::CLG_DIR_DOWN);
   wire [W-1:0] top = (!is_cont && dir_up) ? high_lim : clg_pkg::CLG_MAX;
   wire [W-1:0] bot = (!is_cont && dir_dn) ? clg_pkg::CLG_ZERO
      : clg_pkg::CLG_MIN;
   // once and periodic act on arriving at a limit, continuous on passing it
   wire [W-1:0] top_pre = top - W'(1);
   wire [W-1:0] bot_pre = bot + W'(1);

   // gate
   logic gate_open;
   logic gate_start;
   wire step_up = pins.up & ~pins.dn;
   wire step_dn = pins.dn & ~pins.up;
   wire at_top = is_cont ? (count == top) : (count == top_pre);
   wire at_bot = is_cont ? (count == bot) : (count == bot_pre);
   wire hit_top = gate_open & step_up & at_top;
   wire hit_bot = gate_open & step_dn & at_bot;
   wire limit_stop = is_once & (hit_top | hit_bot);

   clg_gate u_gate (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_sw_bit(i_software_gate_bit),
      .i_hw_en(hw_en),
      .i_hw_level(pins.hw_gate),
      .i_limit_stop(limit_stop),
      .o_open(gate_open),
      .o_start(gate_start)
   );

   wire sync_load = sync_en & pins.sync_ev;
   wire latch_load = latch_en & pins.latch_ev;
   wire staged_evt = gate_start | sync_load | latch_load;

   // next count, priority: direct load, staged event, step
   logic signed [W-1:0] next_count;
   always_comb begin
      next_count = count;
      if (i_direct_count_load) begin
         next_count = i_load_data;
      end else if (staged_evt) begin
         next_count = staged_load_value;
      end else if (hit_top) begin
         if (is_cont) next_count = clg_pkg::CLG_MIN;
         else next_count = staged_load_value;
      end else if (hit_bot) begin
         if (is_cont) next_count = clg_pkg::CLG_MAX;
         else next_count = staged_load_value;
      end else if (gate_open && step_up) begin
         next_count = count + W'(1);
      end else if (gate_open && step_dn) begin
         next_count = count - W'(1);
      end
   end

   // sampled feedback register
   logic [W-1:0] next_fb;
   assign next_fb = i_show_latch ? latch_val : count;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         mode <= clg_pkg::CLG_MODE_CONT;
         dir <= clg_pkg::CLG_DIR_NONE;
         high_lim <= clg_pkg::CLG_MAX;
         hw_en <= 1'b0;
         sync_en <= 1'b0;
         latch_en <= 1'b0;
      end else if (i_param_strobe) begin
         mode <= clg_pkg::clg_mode_t'(i_mode);
         dir <= clg_pkg::clg_dir_t'(i_main_dir);
         high_lim <= i_high_limit;
         hw_en <= i_hw_gate_en;
         sync_en <= i_sync_en;
         latch_en <= i_latch_en;
      end
   end

   // reset states follow the new assignment directly
   wire [W-1:0] assign_rst = (i_main_dir == 2'h3) ? i_high_limit
      : clg_pkg::CLG_RST_DEFAULT;

   // next held words; parameter assignment overrides every write
   wire [W-1:0] next_count_word = i_param_strobe ? assign_rst : next_count;
   wire [W-1:0] next_staged = i_param_strobe ? assign_rst
      : (i_staged_load_wr ? i_load_data : staged_load_value);
   wire [W-1:0] next_latch = i_param_strobe ? assign_rst
      : (latch_load ? count : latch_val);
   wire [W-1:0] next_cmp1 = i_param_strobe ? assign_rst
      : (i_cmp1_wr ? i_load_data : cmp1);
   wire [W-1:0] next_cmp2 = i_param_strobe ? assign_rst
      : (i_cmp2_wr ? i_load_data : cmp2);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         count <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         count <= next_count_word;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         staged_load_value <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         staged_load_value <= next_staged;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         latch_val <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         latch_val <= next_latch;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cmp1 <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         cmp1 <= next_cmp1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         cmp2 <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         cmp2 <= next_cmp2;
      end
   end

   // flags: set wins over the clear done at sampling
   wire next_ovf = hit_top | (ovf & ~pins.sample);
   wire next_unf = hit_bot | (unf & ~pins.sample);

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         ovf <= 1'b0;
      end else begin
         ovf <= next_ovf;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         unf <= 1'b0;
      end else begin
         unf <= next_unf;
      end
   end

   // feedback words change only at the sampling instant
   wire [W-1:0] next_feedback = pins.sample ? next_fb
      : o_feedback;
   wire next_gate_fb = pins.sample ? gate_open : o_gate_open;
   wire next_ovf_fb = pins.sample ? (ovf | hit_top) : o_overflow;
   wire next_unf_fb = pins.sample ? (unf | hit_bot) : o_underflow;

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_fb_valid <= 1'b0;
      end else begin
         o_fb_valid <= pins.sample;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_feedback <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         o_feedback <= next_feedback;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_gate_open <= 1'b0;
      end else begin
         o_gate_open <= next_gate_fb;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_overflow <= 1'b0;
      end else begin
         o_overflow <= next_ovf_fb;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_underflow <= 1'b0;
      end else begin
         o_underflow <= next_unf_fb;
      end
   end

   // comparison values reach the outputs one cycle after they are held
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cmp1 <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         o_cmp1 <= cmp1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cmp2 <= clg_pkg::CLG_RST_DEFAULT;
      end else begin
         o_cmp2 <= cmp2;
      end
   end
endmodule : clg_core

/* File: tb/clg_core_assertions.sv */
// clg_core_assertions: port-level checks on the counter core
// assumes binding to clg_core, one clock, async active-low reset
`timescale 1ns/1ps
module clg_core_assertions #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // inputs
   input wire logic i_param_strobe,
   input wire logic [1:0] i_main_dir,
   input wire logic [W-1:0] i_high_limit,
   input wire logic [W-1:0] i_load_data,
   input wire logic i_cmp1_wr,
   input wire logic i_software_gate_bit,
   input wire logic i_input_sampling_instant,
   // outputs
   input wire logic [W-1:0] o_feedback,
   input wire logic o_gate_open,
   input wire logic o_overflow,
   input wire logic o_fb_valid,
   input wire logic [W-1:0] o_cmp1,
   input wire logic [W-1:0] o_cmp2
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   property p_cmp_dn;
      i_param_strobe && i_main_dir == 2'h3
         |-> ##2 o_cmp1 == $past(i_high_limit, 2)
         && o_cmp2 == $past(i_high_limit, 2);
   endproperty
   a_cmp_dn: assert property (p_cmp_dn)
      else $error("cmp reset high");
   property p_cmp_zero;
      i_param_strobe && i_main_dir != 2'h3
         |-> ##2 o_cmp1 == '0 && o_cmp2 == '0;
   endproperty
   a_cmp_zero: assert property (p_cmp_zero)
      else $error("cmp reset zero");
   property p_cmp_wr;
      i_cmp1_wr |-> ##2 o_cmp1 == $past(i_load_data, 2);
   endproperty
   a_cmp_wr: assert property (p_cmp_wr)
      else $error("cmp1 write");
   property p_fb_after;
      $rose(i_input_sampling_instant) |-> ##[3:4] o_fb_valid;
   endproperty
   a_fb_after: assert property (p_fb_after)
      else $error("no reply");
   property p_fb_cause;
      o_fb_valid |-> $past(i_input_sampling_instant, 3)
         || $past(i_input_sampling_instant, 4);
   endproperty
   a_fb_cause: assert property (p_fb_cause)
      else $error("stray reply");
   property p_fb_pulse;
      o_fb_valid |=> !o_fb_valid;
   endproperty
   a_fb_pulse: assert property (p_fb_pulse)
      else $error("valid too long");
   property p_fb_hold;
      !o_fb_valid |-> $stable(o_feedback) && $stable(o_gate_open);
   endproperty
   a_fb_hold: assert property (p_fb_hold)
      else $error("feedback moved");
   property p_gate_sw;
      (!i_software_gate_bit) [*6] ##0 o_fb_valid |-> !o_gate_open;
   endproperty
   a_gate_sw: assert property (p_gate_sw)
      else $error("gate open");
   c_wrap: cover property (o_fb_valid && o_overflow);
   c_down: cover property (i_param_strobe && i_main_dir == 2'h3);
   c_shut: cover property (o_fb_valid && !o_gate_open);
endmodule : clg_core_assertions

/* File: tb/clg_fb_master.sv */
// clg_fb_master: bus master model, one sampling instant per exchange
// assumes the feedback outputs of clg_core on i_clk_sys
`timescale 1ns/1ps
module clg_fb_master (
   // clock
   input wire logic i_clk_sys,
   // feedback
   input wire logic i_fb_valid,
   input wire logic [31:0] i_feedback,
   input wire logic i_gate_open,
   // sampling instant pin
   output logic o_sample
);
   initial o_sample = 1'b0;
   // gap makes the master answer promptly or slowly
   task exchange(input int gap, output logic [31:0] fb, output logic g,
         output bit ok);
      ok = 1'b0;
      fb = '0;
      g = 1'b0;
      repeat (gap) @(negedge i_clk_sys);
      o_sample = 1'b1;
      for (int n = 0; n < 12 && !ok; n++) begin
         @(negedge i_clk_sys);
         if (n == 1) o_sample = 1'b0;
         if (i_fb_valid === 1'b1) begin
            ok = 1'b1;
            fb = i_feedback;
            g = i_gate_open;
         end
      end
   endtask : exchange
endmodule : clg_fb_master

/* File: tb/counter_load_gate_core_test.sv */
// counter_load_gate_core_test: self-checking bench for clg_core
// assumes clg_pkg, clg_core, the checker and the bus master model
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module counter_load_gate_core_test;
   logic i_clk_sys = 1'b0;
   logic i_nrst = 1'b0;
   logic i_param_strobe = 1'b0;
   logic [1:0] i_mode = 2'h0;
   logic [1:0] i_main_dir = 2'h0;
   logic [31:0] i_high_limit = 32'h0;
   logic i_sync_en = 1'b0;
   logic i_sw = 1'b0;
   logic i_dload = 1'b0;
   logic [31:0] i_load_data = 32'h0;
   logic i_swr = 1'b0;
   logic i_c1 = 1'b0;
   logic i_c2 = 1'b0;
   logic i_up = 1'b0;
   logic i_dn = 1'b0;
   logic i_sync = 1'b0;
   logic i_lat = 1'b0;
   logic i_shl = 1'b0;
   logic sample;
   logic [31:0] o_feedback, o_cmp1, o_cmp2, fb, s, v;
   logic o_gate_open, o_overflow, o_underflow, o_fb_valid, gate;
   logic [1:0] d;
   bit ok;
   int err_count = 0;
   int checks = 0;
   int t = 1;
   int k;
   always #2.5 i_clk_sys = ~i_clk_sys;
   clg_core DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
      .i_param_strobe(i_param_strobe), .i_mode(i_mode),
      .i_main_dir(i_main_dir), .i_high_limit(i_high_limit),
      .i_hw_gate_en(1'b0), .i_sync_en(i_sync_en), .i_latch_en(i_sync_en),
      .i_software_gate_bit(i_sw), .i_direct_count_load(i_dload),
      .i_load_data(i_load_data), .i_staged_load_wr(i_swr),
      .i_cmp1_wr(i_c1), .i_cmp2_wr(i_c2), .i_show_latch(i_shl),
      .i_pulse_up(i_up), .i_pulse_dn(i_dn), .i_hw_gate(1'b0),
      .i_sync(i_sync), .i_latch(i_lat), .i_input_sampling_instant(sample),
      .o_feedback(o_feedback), .o_gate_open(o_gate_open),
      .o_overflow(o_overflow), .o_underflow(o_underflow),
      .o_fb_valid(o_fb_valid), .o_cmp1(o_cmp1), .o_cmp2(o_cmp2));
   clg_fb_master M (.i_clk_sys(i_clk_sys), .i_fb_valid(o_fb_valid),
      .i_feedback(o_feedback), .i_gate_open(o_gate_open), .o_sample(sample));
   function automatic logic [31:0] rst_val(input logic [1:0] dd,
         input logic [31:0] l);
      return (dd == clg_pkg::CLG_DIR_DOWN) ? l : clg_pkg::CLG_ZERO;
   endfunction : rst_val
   task tick(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask : tick
   task summarize;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task fin;
      $display("test %0d done", t);
      t++;
   endtask : fin
   task param(input logic [1:0] m, input logic [1:0] dd, input logic [31:0] l,
         input logic se);
      {i_mode, i_main_dir, i_high_limit, i_sync_en} = {m, dd, l, se};
      i_param_strobe = 1'b1;
      tick(1);
      i_param_strobe = 1'b0;
      tick(1);
   endtask : param
   // kk selects direct load, staged write, cmp1, cmp2
   task ctl(input int kk, input logic [31:0] dat);
      i_load_data = dat;
      {i_dload, i_swr, i_c1, i_c2} = 4'h8 >> kk;
      tick(1);
      {i_dload, i_swr, i_c1, i_c2} = 4'h0;
      tick(1);
   endtask : ctl
   task pulse(input logic up, input int n);
      repeat (n) begin
         {i_up, i_dn} = {up, !up};
         tick(2);
         {i_up, i_dn} = 2'h0;
         tick(2);
      end
   endtask : pulse
   task sw(input logic b);
      i_sw = b;
      tick(2);
   endtask : sw
   task xchg;
      M.exchange($urandom_range(3), fb, gate, ok);
      if (!ok) begin
         err_count++;
         summarize();
      end
   endtask : xchg
   initial begin
      void'($urandom(35149));
      tick(2);
      i_nrst = 1'b1;
      tick(1);
      for (int i = 0; i < 3; i++) begin
         d = (i == 2) ? 2'h3 : 2'(i);
         v = $urandom;
         param(2'h0, d, v, 1'b0);
         xchg();
         `CHK("reset count", rst_val(d, v), fb)
         `CHK("reset cmp2", rst_val(d, v), o_cmp2)
         s = $urandom;
         ctl(2, s);
         ctl(3, ~s);
         tick(1);
         `CHK("cmp1", s, o_cmp1)
         `CHK("cmp2", ~s, o_cmp2)
      end
      fin();
      param(2'h0, 2'h0, 32'h0, 1'b0);
      sw(1'b1);
      v = $urandom;
      ctl(0, v);
      k = $urandom_range(5, 1);
      pulse(1'b1, k);
      xchg();
      `CHK("count", v + 32'(k), fb)
      `CHK("gate", 1'b1, gate)
      sw(1'b0);
      pulse(1'b1, 2);
      xchg();
      `CHK("held", v + 32'(k), fb)
      `CHK("gate", 1'b0, gate)
      sw(1'b1);
      ctl(0, clg_pkg::CLG_MAX);
      pulse(1'b1, 1);
      xchg();
      `CHK("wrap up", clg_pkg::CLG_MIN, fb)
      `CHK("ovf", 1'b1, o_overflow)
      pulse(1'b0, 1);
      xchg();
      `CHK("wrap dn", clg_pkg::CLG_MAX, fb)
      `CHK("unf", 1'b1, o_underflow)
      fin();
      sw(1'b0);
      param(2'h1, 2'h1, 32'h14, 1'b0);
      s = $urandom_range(15, 1);
      ctl(1, s);
      sw(1'b1);
      xchg();
      `CHK("start", s, fb)
      ctl(0, 32'h13);
      pulse(1'b1, 1);
      xchg();
      `CHK("limit", s, fb)
      `CHK("halt", 1'b0, gate)
      pulse(1'b1, 1);
      xchg();
      `CHK("frozen", s, fb)
      fin();
      sw(1'b0);
      v = $urandom_range(1000, 50);
      param(2'h3, 2'h3, v, 1'b0);
      xchg();
      `CHK("rst down", v, fb)
      s = $urandom_range(40, 10);
      ctl(1, s);
      sw(1'b1);
      ctl(0, 32'h5);
      pulse(1'b1, 2);
      xchg();
      `CHK("dir free", 32'h7, fb)
      pulse(1'b0, 7);
      xchg();
      `CHK("zero", s, fb)
      `CHK("running", 1'b1, gate)
      fin();
      sw(1'b0);
      param(2'h3, 2'h0, 32'h0, 1'b0);
      s = $urandom;
      ctl(1, s);
      sw(1'b1);
      for (int i = 0; i < 2; i++) begin
         ctl(0, i ? clg_pkg::CLG_MAX - 1 : clg_pkg::CLG_MIN + 1);
         pulse(i[0], 1);
         xchg();
         `CHK("either limit", s, fb)
      end
      fin();
      sw(1'b0);
      param(2'h0, 2'h0, 32'h0, 1'b1);
      s = $urandom;
      ctl(1, s);
      sw(1'b1);
      ctl(0, 32'h3);
      i_sync = 1'b1;
      tick(2);
      i_sync = 1'b0;
      tick(2);
      xchg();
      `CHK("sync", s, fb)
      ctl(0, 32'h9);
      i_lat = 1'b1;
      tick(2);
      i_lat = 1'b0;
      tick(2);
      xchg();
      `CHK("latch load", s, fb)
      i_shl = 1'b1;
      xchg();
      `CHK("latch shown", 32'h9, fb)
      i_shl = 1'b0;
      fin();
      summarize();
   end
endmodule : counter_load_gate_core_test
bind clg_core clg_core_assertions #(.W(W)) u_chk (.i_clk_sys(i_clk_sys),
   .i_nrst(i_nrst), .i_param_strobe(i_param_strobe),
   .i_main_dir(i_main_dir), .i_high_limit(i_high_limit),
   .i_load_data(i_load_data), .i_cmp1_wr(i_cmp1_wr),
   .i_software_gate_bit(i_software_gate_bit),
   .i_input_sampling_instant(i_input_sampling_instant),
   .o_feedback(o_feedback), .o_gate_open(o_gate_open),
   .o_overflow(o_overflow), .o_fb_valid(o_fb_valid), .o_cmp1(o_cmp1),
   .o_cmp2(o_cmp2));
